// >>> common/mgmt_defines.vh
// Constants for the management serial port: offsets, fields, resets, timing.
// Included by the design files; definitions only.
`ifndef MGMT_DEFINES_VH
`define MGMT_DEFINES_VH

// Register byte addresses
`define ADDR_CTRL_OFFSET   32'hE001_0044
`define DATA_OFFSET        32'hE001_0048
`define IRQ_STATUS_OFFSET  32'hE001_0050
`define IRQ_CLEAR_OFFSET   32'hE001_0054
`define IRQ_ENABLE_OFFSET  32'hE001_0058

// Address/control field positions
`define PHY_MSB    15
`define PHY_LSB    11
`define REGNUM_MSB 10
`define REGNUM_LSB 6
`define WRITE_BIT  1
`define BUSY_BIT   0

// Interrupt status bits
`define EVT_DONE   0
`define EVT_REJECT 1

// Reset values
`define ADDR_CTRL_RESET  16'h0000
`define DATA_RESET       16'h0000
`define IRQ_ENABLE_RESET 2'h0

// Frame layout
`define PREAMBLE   32'hFFFF_FFFF
`define START_CODE 2'h1
`define OP_READ    2'h2
`define OP_WRITE   2'h1
`define TA_WRITE   2'h2
`define FRAME_LAST 7'h3F
`define TA_FIRST   7'h2E
`define DATA_FIRST 7'h30

// Timing
`define CLK_PERIOD_NS 50
`define MDC_HALF_NS   200
`define MDC_HALF_CYC  ((`MDC_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> rtl/mgmt_input_sync.v
// Two-flop synchroniser for one level arriving from outside the clock domain.
// Assumes the input is asynchronous to clock; output lags by two edges.
`timescale 1ns/1ns
`default_nettype none

module mgmt_input_sync (
  // Clock and control
  input  wire clock,
  input  wire reset,
  input  wire clockEnable,
  // Level in and out
  input  wire asyncIn,
  output wire syncOut
);

  reg stage1_reg;
  reg stage2_reg;

  // First stage feeds only the second
  always @(posedge clock) begin
    if (reset) begin
      stage1_reg <= 1'b1;
      stage2_reg <= 1'b1;
    end else if (clockEnable) begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule // mgmt_input_sync

`default_nettype wire

// >>> rtl/mgmt_clock_divider.v
// Management clock generator: divides clock into the serial clock.
// Assumes run is held high for a whole frame; clock idles low otherwise.
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_defines.vh"

module mgmt_clock_divider (
  // Clock and control
  input  wire clock,
  input  wire reset,
  input  wire clockEnable,
  input  wire run,
  // Serial clock and its edge strobes
  output wire mdc,
  output wire risePulse,
  output wire fallPulse
);

  localparam integer HALF_CYC  = `MDC_HALF_CYC;
  localparam [2:0]   HALF_LAST = HALF_CYC[2:0] - 3'h1;

  reg [2:0] count_reg;
  reg       mdc_reg;
  wire      wrap;

  assign wrap      = run & (count_reg == HALF_LAST);
  assign risePulse = wrap & ~mdc_reg;
  assign fallPulse = wrap & mdc_reg;
  assign mdc       = mdc_reg;

  // Half-period counter, toggles the clock at each wrap
  always @(posedge clock) begin
    if (reset) begin
      count_reg <= 3'h0;
      mdc_reg   <= 1'b0;
    end else if (clockEnable) begin
      if (!run) begin
        count_reg <= 3'h0;
        mdc_reg   <= 1'b0;
      end else if (wrap) begin
        count_reg <= 3'h0;
        mdc_reg   <= ~mdc_reg;
      end else begin
        count_reg <= count_reg + 3'h1;
      end
    end
  end

endmodule // mgmt_clock_divider

`default_nettype wire

// >>> rtl/mdio_phy_register_access.v
// Management port: APB registers launch one read or write frame on the
// serial management link to an external PHY register.
// Assumes an APB master on clock, a pull-up on the data line, PHYs that
// answer in the standard frame format.
//
// Overview of operation
// - Address register holds PHY and register numbers
// - Writing address register while idle launches one transaction
// - Write bit one sends data register out
// - Write bit zero reads into data register
// - Busy set for whole transaction, then cleared
// - Read data invalid until busy clears
// - Data register holds sixteen-bit word
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_defines.vh"

module mdio_phy_register_access (
  // Clock, reset and enable
  input  wire        clock,
  input  wire        reset,
  input  wire        clockEnable,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // Management link
  output wire        mdc,
  input  wire        mdioIn,
  output reg         mdioOut,
  output reg         mdioOutEnable,
  // Interrupt
  output wire        irq
);

  // Sequencer states, one-hot: idle waits for a launch, shift runs a frame
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;

  // Frame bit positions, counted from the first preamble bit:
  //   0..31  preamble of ones, lets the PHY find the frame
  //   32..33 start code
  //   34..35 opcode, read or write
  //   36..40 target PHY number, MSB first
  //   41..45 register number, MSB first
  //   46..47 turnaround; a read hands the line to the PHY here
  //   48..63 data word, MSB first
  // The counter advances on each falling serial edge, so during bit k
  // the PHY samples at the rising edge that follows.

  // Registers
  reg  [4:0]  phyNumber_reg;
  reg  [4:0]  regNumber_reg;
  reg         writeOp_reg;
  reg  [15:0] data_reg;
  reg  [1:0]  irqStatus_reg;
  reg  [1:0]  irqEnable_reg;
  reg  [1:0]  state_reg;
  reg  [63:0] frame_reg;
  reg  [6:0]  bitCount_reg;
  reg  [15:0] readShift_reg;
  reg         latched_reg;
  reg  [31:0] readMux;
  reg         hit;
  reg  [1:0]  irqStatus_next;
  reg  [1:0]  irqSet;

  wire        busy;
  wire        setupPhase;
  wire        accessDone;
  wire        wrAddr;
  wire        wrData;
  wire        wrClear;
  wire        wrEnable;
  wire        launch;
  wire        finish;
  wire        mdioSync;
  wire        risePulse;
  wire        fallPulse;
  wire [6:0]  nextCount;
  wire [1:0]  opcode;
  wire [1:0]  turnaround;
  wire [15:0] ctrlReset;
  wire        lineHeld;

  // Busy is the shift state itself
  assign busy = state_reg[1];

  // Reset image of the address register, split into its fields below
  assign ctrlReset = `ADDR_CTRL_RESET;

  // Serial clock generator, runs only while a frame is out
  // It stops and returns low as soon as busy clears, so the serial
  // clock stands still between frames.
  mgmt_clock_divider clockGen (
    .clock       (clock),
    .reset       (reset),
    .clockEnable (clockEnable),
    .run         (busy),
    .mdc         (mdc),
    .risePulse   (risePulse),
    .fallPulse   (fallPulse)
  );

  // Data line from the PHY crosses into the clock domain
  // The two-edge lag is covered: the PHY drives a bit a whole serial
  // period before the rising edge at which it is captured.
  mgmt_input_sync mdioSyncer (
    .clock       (clock),
    .reset       (reset),
    .clockEnable (clockEnable),
    .asyncIn     (mdioIn),
    .syncOut     (mdioSync)
  );

  // APB phases: read data latched at setup, answer in access phase
  // Zero wait states: pready rises in the first access cycle
  // and is held low while the clock enable freezes the block.
  assign setupPhase = psel & ~penable;
  assign pready     = clockEnable & latched_reg;
  assign accessDone = psel & penable & pready;
  assign wrAddr   = accessDone & pwrite & (paddr == `ADDR_CTRL_OFFSET);
  assign wrData   = accessDone & pwrite & (paddr == `DATA_OFFSET);
  assign wrClear  = accessDone & pwrite & (paddr == `IRQ_CLEAR_OFFSET);
  assign wrEnable = accessDone & pwrite & (paddr == `IRQ_ENABLE_OFFSET);

  // A launch is taken only from idle; a write while busy is refused
  assign launch = wrAddr & ~busy;
  assign finish = busy & fallPulse & (bitCount_reg == `FRAME_LAST);

  // Opcode and turnaround follow the write bit of the launching value
  assign opcode     = pwdata[`WRITE_BIT] ? `OP_WRITE : `OP_READ;
  assign turnaround = pwdata[`WRITE_BIT] ? `TA_WRITE : 2'h0;
  assign nextCount  = bitCount_reg + 7'h01;

  // Device owns the line for a write, and for a read up to turnaround
  assign lineHeld   = writeOp_reg | (nextCount < `TA_FIRST);

  // Address decode and read mux
  always @* begin
    hit     = 1'b1;
    readMux = 32'h0000_0000;
    case (paddr)
      `ADDR_CTRL_OFFSET: begin
        readMux[`PHY_MSB:`PHY_LSB]       = phyNumber_reg;
        readMux[`REGNUM_MSB:`REGNUM_LSB] = regNumber_reg;
        readMux[`WRITE_BIT]              = writeOp_reg;
        readMux[`BUSY_BIT]               = busy;
      end
      `DATA_OFFSET:       readMux[15:0] = data_reg;
      `IRQ_STATUS_OFFSET: readMux[1:0]  = irqStatus_reg;
      `IRQ_CLEAR_OFFSET:  readMux       = 32'h0000_0000;
      `IRQ_ENABLE_OFFSET: readMux[1:0]  = irqEnable_reg;
      default:            hit           = 1'b0;
    endcase
  end

  // APB answer: read data and error latched in the setup cycle
  always @(posedge clock) begin
    if (reset) begin
      prdata      <= 32'h0000_0000;
      pslverr     <= 1'b0;
      latched_reg <= 1'b0;
    end else if (clockEnable) begin
      if (setupPhase) begin
        prdata      <= pwrite ? 32'h0000_0000 : readMux;
        pslverr     <= ~hit;
        latched_reg <= 1'b1;
      end else if (accessDone) begin
        latched_reg <= 1'b0;
        pslverr     <= 1'b0;
      end
    end
  end

  // Address/control register; busy and reserved bits are not stored
  // A write while busy leaves the fields untouched and raises flag 1
  always @(posedge clock) begin
    if (reset) begin
      phyNumber_reg <= ctrlReset[`PHY_MSB:`PHY_LSB];
      regNumber_reg <= ctrlReset[`REGNUM_MSB:`REGNUM_LSB];
      writeOp_reg   <= ctrlReset[`WRITE_BIT];
    end else if (clockEnable && launch) begin
      phyNumber_reg <= pwdata[`PHY_MSB:`PHY_LSB];
      regNumber_reg <= pwdata[`REGNUM_MSB:`REGNUM_LSB];
      writeOp_reg   <= pwdata[`WRITE_BIT];
    end
  end

  // Data register: software write, or the word returned by a read
  // A read's finish wins over a software write in the same cycle;
  // software is not to write here while busy.
  always @(posedge clock) begin
    if (reset) begin
      data_reg <= `DATA_RESET;
    end else if (clockEnable) begin
      if (finish && !writeOp_reg) begin
        data_reg <= readShift_reg;
      end else if (wrData) begin
        data_reg <= pwdata[15:0];
      end
    end
  end

  // Frame sequencer: shifts the frame out on falling serial edges
  // Bit 0 is put out at launch; each later bit follows a falling edge.
  always @(posedge clock) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      frame_reg     <= 64'h0000_0000_0000_0000;
      bitCount_reg  <= 7'h00;
      mdioOut       <= 1'b1;
      mdioOutEnable <= 1'b0;
    end else if (clockEnable) begin
      case (state_reg)
        ST_IDLE: begin
          mdioOutEnable <= 1'b0;
          if (launch) begin
            // Preamble, start, opcode, addresses, turnaround, data
            frame_reg <= {`PREAMBLE, `START_CODE, opcode,
                          pwdata[`PHY_MSB:`PHY_LSB],
                          pwdata[`REGNUM_MSB:`REGNUM_LSB],
                          turnaround, data_reg};
            bitCount_reg  <= 7'h00;
            mdioOut       <= 1'b1;
            mdioOutEnable <= 1'b1;
            state_reg     <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (fallPulse) begin
            if (finish) begin
              mdioOutEnable <= 1'b0;
              mdioOut       <= 1'b1;
              state_reg     <= ST_IDLE;
            end else begin
              bitCount_reg  <= nextCount;
              frame_reg     <= {frame_reg[62:0], 1'b0};
              mdioOut       <= frame_reg[62];
              // Release the line from turnaround on for a read
              mdioOutEnable <= lineHeld;
            end
          end
        end
        default: begin
          state_reg     <= ST_IDLE;
          mdioOutEnable <= 1'b0;
        end
      endcase
    end
  end

  // Read data captured on rising serial edges of the data field
  // Sixteen rising edges, bits 48 to 63, fill the shift register
  always @(posedge clock) begin
    if (reset) begin
      readShift_reg <= 16'h0000;
    end else if (clockEnable) begin
      if (busy && risePulse && !writeOp_reg &&
          bitCount_reg >= `DATA_FIRST) begin
        readShift_reg <= {readShift_reg[14:0], mdioSync};
      end
    end
  end

  // Sticky interrupt status; a new event wins over a clear
  // Bit 0 marks a finished frame, bit 1 a launch refused while busy.
  always @* begin
    irqSet                 = 2'h0;
    irqSet[`EVT_DONE]      = finish;
    irqSet[`EVT_REJECT]    = wrAddr & busy;
    irqStatus_next         = irqStatus_reg;
    if (wrClear) begin
      irqStatus_next = irqStatus_reg & ~pwdata[1:0];
    end
    irqStatus_next = irqStatus_next | irqSet;
  end

  // Interrupt status and enable registers
  always @(posedge clock) begin
    if (reset) begin
      irqStatus_reg <= 2'h0;
      irqEnable_reg <= `IRQ_ENABLE_RESET;
    end else if (clockEnable) begin
      irqStatus_reg <= irqStatus_next;
      if (wrEnable) begin
        irqEnable_reg <= pwdata[1:0];
      end
    end
  end

  // Level interrupt: any enabled status bit that is set
  assign irq = |(irqStatus_reg & irqEnable_reg);

endmodule // mdio_phy_register_access

`default_nettype wire

// >>> sim/mdio_phy_register_access_assertions.sv
// Checker for the management port, watching top-level ports only.
// Assumes the shared constants header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_defines.vh"
module mgmt_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        clockEnable,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Link
  input wire logic        mdc,
  input wire logic        mdioOut,
  input wire logic        mdioOutEnable
);
  logic [3:0] quietCnt;
  wire acc = psel && penable && pready;
  wire ctrlWr = acc && pwrite && paddr == `ADDR_CTRL_OFFSET;
  // Cycles since the link last moved; saturates
  always @(posedge clock) begin
    if (reset || mdc || mdioOutEnable)
      quietCnt <= 4'h0;
    else if (quietCnt != 4'hF)
      quietCnt <= quietCnt + 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_zeroWait; psel && penable && clockEnable |-> pready; endproperty
  a_zeroWait: assert property (p_zeroWait)
    else $error("pready missing in access phase");
  property p_launch; ctrlWr && quietCnt == 4'hF |=>
    mdioOutEnable ##4 $rose(mdc); endproperty
  a_launch: assert property (p_launch)
    else $error("frame did not start after launch");
  property p_mdcHigh; $rose(mdc) |-> mdc [*4] ##1 !mdc; endproperty
  a_mdcHigh: assert property (p_mdcHigh)
    else $error("mdc high phase wrong");
  property p_mdcLow; $fell(mdc) |-> !mdc [*4]; endproperty
  a_mdcLow: assert property (p_mdcLow)
    else $error("mdc low phase wrong");
  property p_preamble; $rose(mdioOutEnable) |-> mdioOut [*8]; endproperty
  a_preamble: assert property (p_preamble)
    else $error("preamble not ones");
  property p_dataChg; mdioOutEnable && $past(mdioOutEnable) &&
    $changed(mdioOut) |-> $past(mdc) && !mdc; endproperty
  a_dataChg: assert property (p_dataChg)
    else $error("data changed off mdc fall");
  property p_upper; acc && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits set");
  property p_mapped; acc && (paddr == `ADDR_CTRL_OFFSET ||
    paddr == `DATA_OFFSET) |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped)
    else $error("error on mapped register");
  // Main scenarios
  c_launch: cover property (ctrlWr);
  c_frameEnd: cover property ($fell(mdioOutEnable));
  c_slvErr: cover property (acc && pslverr);
endmodule // mgmt_checker
bind mdio_phy_register_access mgmt_checker chk (.clock(clock),
  .reset(reset), .clockEnable(clockEnable), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mdc(mdc), .mdioOut(mdioOut),
  .mdioOutEnable(mdioOutEnable));
`default_nettype wire

// >>> sim/mgmt_phy_model.sv
// Behavioural PHY on the management link: decodes frames, answers reads.
// Assumes mdc idles low between frames and a pull-up on the line.
`timescale 1ns/1ns
`default_nettype none
module mgmt_phy_model #(
  parameter logic [15:0] READ_WORD = 16'h3C96
) (
  // Link
  input  wire logic        mdc,
  input  wire logic        mdioOutEnable,
  input  wire logic        line,
  output var  logic        phyOut,
  output var  logic        phyOe,
  // Decoded frame
  output var  logic [15:0] header,
  output var  logic [15:0] shiftReg,
  output var  logic        preambleBad
);
  logic [6:0] bitCnt;
  initial phyOe = 1'b0;
  // Sample on rising mdc; a rising enable with mdc low starts a frame
  always @(posedge mdc or posedge mdioOutEnable) begin
    if (!mdc) begin
      bitCnt <= 7'h00;
      preambleBad <= 1'b0;
    end else begin
      bitCnt <= bitCnt + 7'h01;
      shiftReg <= {shiftReg[14:0], line};
      if (bitCnt < 7'd32 && !line)
        preambleBad <= 1'b1;
      if (bitCnt == 7'd46)
        header <= shiftReg;
      if (bitCnt == 7'd46)
        phyOe <= shiftReg[11:10] == 2'b10;
      if (bitCnt == 7'd63)
        phyOe <= 1'b0;
      phyOut <= bitCnt > 7'd46 ? READ_WORD[4'(7'd62 - bitCnt)] : 1'b0;
    end
  end
endmodule // mgmt_phy_model
`default_nettype wire

// >>> sim/mdio_phy_register_access_tb_top.sv
// Testbench: APB accesses launch frames to a PHY model and are checked.
// Assumes the shared constants header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "mgmt_defines.vh"
module mdio_phy_register_access_tb_top;
  logic clock, reset, psel, penable, pwrite, pslverr, pready, irq;
  logic [31:0] paddr, pwdata, prdata, rdVal;
  logic mdc, mdioOut, mdioOutEnable, phyOut, phyOe, preBad, errVal;
  logic [15:0] header, shiftReg;
  int nFail = 0;
  int cmpCount = 0;
  // Wire with pull-up
  wire logic line = mdioOutEnable ? mdioOut : (phyOe ? phyOut : 1'b1);
  mdio_phy_register_access DUT (.clock(clock), .reset(reset),
    .clockEnable(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mdc(mdc), .mdioIn(line), .mdioOut(mdioOut),
    .mdioOutEnable(mdioOutEnable), .irq(irq));
  mgmt_phy_model phy (.mdc(mdc), .mdioOutEnable(mdioOutEnable),
    .line(line), .phyOut(phyOut), .phyOe(phyOe), .header(header),
    .shiftReg(shiftReg), .preambleBad(preBad));
  // Setup, then access until pready is seen high at a rising edge;
  // one idle edge after the release keeps calls apart
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      nFail++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task waitIdle;
    rdVal = 32'h0000_0001;
    while (rdVal[0] === 1'b1) apb(0, `ADDR_CTRL_OFFSET, 0);
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Watchdog
  initial begin
    repeat (4000) @(posedge clock);
    nFail++;
    print_verdict;
  end
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 64'h0};
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    apb(0, `ADDR_CTRL_OFFSET, 0);
    chk("ctrl", 0, rdVal);
    apb(0, `DATA_OFFSET, 0);
    chk("data", 0, rdVal);
    apb(0, 32'hE001_004C, 0);
    chk("slverr", 1, errVal);
    $display("test reset done");
    // Write frame, with a refused relaunch while busy and masked
    apb(1, `IRQ_ENABLE_OFFSET, 1);
    apb(1, `DATA_OFFSET, 32'h0000_A5C3);
    apb(1, `ADDR_CTRL_OFFSET, 32'h0000_9A82);
    apb(0, `ADDR_CTRL_OFFSET, 0);
    chk("busy", 1, rdVal[0]);
    apb(1, `ADDR_CTRL_OFFSET, 32'h0000_0002);
    chk("irqMasked", 0, irq);
    waitIdle;
    chk("header", 16'hD66A, header);
    chk("wrData", 16'hA5C3, shiftReg);
    chk("preamble", 0, preBad);
    chk("irqDone", 1, irq);
    apb(0, `IRQ_STATUS_OFFSET, 0);
    chk("status", 3, rdVal);
    apb(1, `IRQ_CLEAR_OFFSET, 3);
    chk("irqClr", 0, irq);
    $display("test write done");
    // Read frame
    apb(1, `ADDR_CTRL_OFFSET, 32'h0000_0FC0);
    waitIdle;
    chk("header", 16'hD83F, header);
    apb(0, `DATA_OFFSET, 0);
    chk("rdData", 32'h0000_3C96, rdVal);
    $display("test read done");
    print_verdict;
  end
endmodule // mdio_phy_register_access_tb_top
`default_nettype wire
